// File: dmachr_top.v
// Seven-channel DMA register file, flags, arbiter and channel stepping.
// Assumes an Avalon-MM master and a transfer engine on SYS_CLK;
// peripheral requests come from logic on the same clock.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dmachr_defs.vh"

module dmachr_top #(
  parameter NCH = 7
) (
  // Clock and reset
  input  wire          SYS_CLK,
  input  wire          RST_N,
  // Avalon-MM slave
  input  wire [7:0]    AV_ADDRESS,
  input  wire          AV_READ,
  input  wire          AV_WRITE,
  input  wire [31:0]   AV_WRITEDATA,
  input  wire [3:0]    AV_BYTEENABLE,
  output reg  [31:0]   AV_READDATA,
  output wire          AV_WAITREQUEST,
  // Peripheral requests
  input  wire [NCH-1:0] PERIPH_REQ,
  // Transfer engine
  output wire          XFER_REQ,
  output reg  [2:0]    XFER_CH,
  output reg           XFER_DIR,
  output reg           XFER_COPY,
  output reg  [31:0]   XFER_PADDR,
  output reg  [31:0]   XFER_MADDR,
  output reg  [1:0]    XFER_PWIDTH,
  output reg  [1:0]    XFER_MWIDTH,
  input  wire          XFER_ACK,
  input  wire          XFER_ERR,
  // Channel interrupts
  output wire [NCH-1:0] CH_IRQ
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  function [31:0] merge;
    input [31:0] o;
    input [31:0] n;
    input [3:0]  be;
    begin
      merge = {be[3] ? n[31:24] : o[31:24], be[2] ? n[23:16] : o[23:16],
               be[1] ? n[15:8]  : o[15:8],  be[0] ? n[7:0]   : o[7:0]};
    end
  endfunction

  function [31:0] step;
    input [1:0] w;
    begin
      case (w)
        `DMACHR_W8:  step = 32'h0000_0001;
        `DMACHR_W16: step = 32'h0000_0002;
        default:     step = 32'h0000_0004;
      endcase
    end
  endfunction

  function [31:0] align;
    input [31:0] a;
    input [1:0]  w;
    begin
      case (w)
        `DMACHR_W8:  align = a;
        `DMACHR_W16: align = {a[31:1], 1'b0};
        default:     align = {a[31:2], 2'b00};
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  reg         ack;
  wire        wr_take = AV_WRITE & ack;
  wire [31:0] clr_bits = AV_WRITEDATA &
                         {{8{AV_BYTEENABLE[3]}}, {8{AV_BYTEENABLE[2]}},
                          {8{AV_BYTEENABLE[1]}}, {8{AV_BYTEENABLE[0]}}};
  wire        wr_clr = wr_take && AV_ADDRESS == `DMACHR_CLR_OFF;

  assign AV_WAITREQUEST = (AV_READ | AV_WRITE) & ~ack;

  // ----------------------------------------------------------------
  // Engine state shared with channels
  // ----------------------------------------------------------------
  reg        state;
  reg  [2:0] gnt;
  wire       fin = (state == ST_BUSY) & XFER_ACK;

  wire [NCH-1:0]       elig;
  wire [2*NCH-1:0]     pri_all;
  wire [32*NCH-1:0]    pa_all;
  wire [32*NCH-1:0]    ma_all;
  wire [`DMACHR_CFG_W*NCH-1:0] cfg_all;
  wire [32*NCH-1:0]    rd_all;
  wire [4*NCH-1:0]     sts_all;

  // ----------------------------------------------------------------
  // Per-channel registers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      localparam [31:0] OFS_W = g * `DMACHR_CH_STRIDE;
      localparam [31:0] ID_W  = g;
      localparam [7:0]  OFS   = OFS_W[7:0];
      localparam [2:0]  ID    = ID_W[2:0];
      reg  [`DMACHR_CFG_W-1:0] cfg;
      reg  [`DMACHR_CNT_W-1:0] cnt;
      reg  [`DMACHR_CNT_W-1:0] base_cnt;
      reg  [31:0] base_pa;
      reg  [31:0] base_ma;
      reg  [31:0] cur_pa;
      reg  [31:0] cur_ma;
      reg  [3:0]  flg;
      wire a_cfg = AV_ADDRESS == `DMACHR_CFG_OFF + OFS;
      wire a_cnt = AV_ADDRESS == `DMACHR_CNT_OFF + OFS;
      wire a_pa  = AV_ADDRESS == `DMACHR_PA_OFF + OFS;
      wire a_ma  = AV_ADDRESS == `DMACHR_MA_OFF + OFS;
      wire on    = cfg[`DMACHR_C_ON];
      wire circ  = cfg[`DMACHR_C_CIRC];
      wire [1:0] pw = cfg[`DMACHR_C_PW_HI:`DMACHR_C_PW_LO];
      wire [1:0] mw = cfg[`DMACHR_C_MW_HI:`DMACHR_C_MW_LO];
      wire [31:0] m32 = merge({16'h0000, cnt}, AV_WRITEDATA, AV_BYTEENABLE);
      wire [31:0] mpa = merge(base_pa, AV_WRITEDATA, AV_BYTEENABLE);
      wire [31:0] mma = merge(base_ma, AV_WRITEDATA, AV_BYTEENABLE);
      wire [31:0] mcf = merge({17'h0, cfg}, AV_WRITEDATA, AV_BYTEENABLE);
      wire hit  = fin && gnt == ID;
      wire good = hit & ~XFER_ERR;
      wire [`DMACHR_CNT_W-1:0] dec = cnt - 16'h0001;
      wire last = dec == 16'h0000;
      wire ev_done  = good & last;
      wire ev_half  = good &&
                      dec == {1'b0, base_cnt[`DMACHR_CNT_W-1:1]};
      wire ev_fault = hit & XFER_ERR;
      wire ev_any   = ev_done | ev_half | ev_fault;
      wire [3:0] clr = wr_clr ? clr_bits[4*g +: 4] : 4'h0;
      wire c_any = clr[`DMACHR_F_ANY];

      always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          cfg      <= {`DMACHR_CFG_W{1'b0}};
          cnt      <= {`DMACHR_CNT_W{1'b0}};
          base_cnt <= {`DMACHR_CNT_W{1'b0}};
          base_pa  <= `DMACHR_RST32;
          base_ma  <= `DMACHR_RST32;
          cur_pa   <= `DMACHR_RST32;
          cur_ma   <= `DMACHR_RST32;
          flg      <= 4'h0;
        end else begin
          // Set wins over clear; only one-bits clear
          flg[`DMACHR_F_ANY]   <= ev_any |
            (flg[`DMACHR_F_ANY] & ~c_any);
          flg[`DMACHR_F_DONE]  <= ev_done |
            (flg[`DMACHR_F_DONE] & ~(c_any | clr[`DMACHR_F_DONE]));
          flg[`DMACHR_F_HALF]  <= ev_half |
            (flg[`DMACHR_F_HALF] & ~(c_any | clr[`DMACHR_F_HALF]));
          flg[`DMACHR_F_FAULT] <= ev_fault |
            (flg[`DMACHR_F_FAULT] & ~(c_any | clr[`DMACHR_F_FAULT]));
          // Config; reserved bits dropped, fault stops the channel
          if (wr_take & a_cfg)
            cfg <= mcf[`DMACHR_CFG_W-1:0];
          else if (ev_fault)
            cfg[`DMACHR_C_ON] <= 1'b0;
          // Count and addresses writable only while disabled
          if (wr_take & a_cnt & ~on) begin
            cnt      <= m32[`DMACHR_CNT_W-1:0];
            base_cnt <= m32[`DMACHR_CNT_W-1:0];
            cur_pa   <= base_pa;
            cur_ma   <= base_ma;
          end else if (wr_take & a_pa & ~on) begin
            base_pa <= mpa;
            cur_pa  <= mpa;
          end else if (wr_take & a_ma & ~on) begin
            base_ma <= mma;
            cur_ma  <= mma;
          end else if (good) begin
            if (last & circ) begin
              cnt    <= base_cnt;
              cur_pa <= base_pa;
              cur_ma <= base_ma;
            end else begin
              cnt <= dec;
              if (cfg[`DMACHR_C_PSTEP])
                cur_pa <= cur_pa + step(pw);
              if (cfg[`DMACHR_C_MSTEP])
                cur_ma <= cur_ma + step(mw);
            end
          end
        end
      end

      assign elig[g] = on && cnt != 16'h0000 &&
                       (cfg[`DMACHR_C_COPY] | PERIPH_REQ[g]);
      assign pri_all[2*g +: 2] =
        cfg[`DMACHR_C_PRI_HI:`DMACHR_C_PRI_LO];
      assign pa_all[32*g +: 32] = align(cur_pa, pw);
      assign ma_all[32*g +: 32] = align(cur_ma, mw);
      assign cfg_all[`DMACHR_CFG_W*g +: `DMACHR_CFG_W] = cfg;
      assign sts_all[4*g +: 4] = flg;
      assign CH_IRQ[g] = |(flg[`DMACHR_F_FAULT:`DMACHR_F_DONE] &
                           cfg[`DMACHR_C_FAULT_IE:`DMACHR_C_DONE_IE]);
      assign rd_all[32*g +: 32] =
        a_cfg ? {17'h0, cfg} :
        a_cnt ? {16'h0000, cnt} :
        a_pa  ? base_pa :
        a_ma  ? base_ma : `DMACHR_RST32;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;
  integer    k;

  always @* begin
    rd_mux = `DMACHR_RST32;
    if (AV_ADDRESS == `DMACHR_STS_OFF)
      rd_mux[`DMACHR_STS_W-1:0] = sts_all[`DMACHR_STS_W-1:0];
    for (k = 0; k < NCH; k = k + 1)
      rd_mux = rd_mux | rd_all[32*k +: 32];
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack         <= 1'b0;
      AV_READDATA <= `DMACHR_RST32;
    end else begin
      ack <= (AV_READ | AV_WRITE) & ~ack;
      if (AV_READ & ~ack)
        AV_READDATA <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  reg [2:0] pick;
  reg [1:0] pbest;
  reg       found;
  integer   i;

  always @* begin
    pick  = 3'h0;
    pbest = 2'b00;
    found = 1'b0;
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (elig[i] && (!found || pri_all[2*i +: 2] >= pbest)) begin
        pick  = i[2:0];
        pbest = pri_all[2*i +: 2];
        found = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer issue
  // ----------------------------------------------------------------
  assign XFER_REQ = state == ST_BUSY;

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state       <= ST_IDLE;
      gnt         <= 3'h0;
      XFER_CH     <= 3'h0;
      XFER_DIR    <= 1'b0;
      XFER_COPY   <= 1'b0;
      XFER_PADDR  <= `DMACHR_RST32;
      XFER_MADDR  <= `DMACHR_RST32;
      XFER_PWIDTH <= `DMACHR_W8;
      XFER_MWIDTH <= `DMACHR_W8;
    end else begin
      case (state)
        ST_IDLE: begin
          if (found) begin
            state       <= ST_BUSY;
            gnt         <= pick;
            XFER_CH     <= pick;
            XFER_DIR    <=
              cfg_all[`DMACHR_CFG_W*pick + `DMACHR_C_DIR];
            XFER_COPY   <=
              cfg_all[`DMACHR_CFG_W*pick + `DMACHR_C_COPY];
            XFER_PADDR  <= pa_all[32*pick +: 32];
            XFER_MADDR  <= ma_all[32*pick +: 32];
            XFER_PWIDTH <=
              cfg_all[`DMACHR_CFG_W*pick + `DMACHR_C_PW_LO +: 2];
            XFER_MWIDTH <=
              cfg_all[`DMACHR_CFG_W*pick + `DMACHR_C_MW_LO +: 2];
          end
        end
        ST_BUSY: begin
          if (XFER_ACK)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // dmachr_top
`default_nettype wire

// File: dmachr_defs.vh
// Constants for the seven-channel DMA register block.
// Assumes inclusion by bare name from the design file.
// Function
// - Four flags per channel, nibble packed, top reserved
// - Any event also sets channel any_event_flag
// - done_flag set when count reaches zero
// - halfway_flag set at half of count
// - fault_flag set on transfer error
// - Flags hardware set, cleared only by one
// - any_event_clear clears all four channel flags
// - Other clear bits clear only their flag
// - Config bits 0..3 enable channel and irqs
// - Bit 4 selects transfer direction
// - Bit 5 enables auto reload
// - Bits 6, 7 enable address stepping
// - Bits 9:8 peripheral width, 00/01/10 = 8/16/32 bit
// - Bits 11:10 memory width, same encoding
// - Bits 13:12 software priority level
// - Bit 14 copy mode, 31:15 reserved
// - Channel registers at base plus 20 per channel
// - Status, clear, config reset to zero
// - Highest priority wins, then lowest channel
// - Auto reload restores count and both addresses
// - Copy mode runs without requests until zero
// - Stepped address adds data width size
`ifndef DMACHR_DEFS_VH
`define DMACHR_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DMACHR_STS_OFF    8'h00
`define DMACHR_CLR_OFF    8'h04
`define DMACHR_CFG_OFF    8'h08
`define DMACHR_CNT_OFF    8'h0c
`define DMACHR_PA_OFF     8'h10
`define DMACHR_MA_OFF     8'h14
`define DMACHR_CH_STRIDE  8'h14

// ----------------------------------------------------------------
// Flag nibble positions
// ----------------------------------------------------------------
`define DMACHR_F_ANY      0
`define DMACHR_F_DONE     1
`define DMACHR_F_HALF     2
`define DMACHR_F_FAULT    3
`define DMACHR_STS_W      28

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define DMACHR_C_ON       0
`define DMACHR_C_DONE_IE  1
`define DMACHR_C_FAULT_IE 3
`define DMACHR_C_DIR      4
`define DMACHR_C_CIRC     5
`define DMACHR_C_PSTEP    6
`define DMACHR_C_MSTEP    7
`define DMACHR_C_PW_HI    9
`define DMACHR_C_PW_LO    8
`define DMACHR_C_MW_HI    11
`define DMACHR_C_MW_LO    10
`define DMACHR_C_PRI_HI   13
`define DMACHR_C_PRI_LO   12
`define DMACHR_C_COPY     14
`define DMACHR_CFG_W      15
`define DMACHR_CNT_W      16

// ----------------------------------------------------------------
// Width codes and reset values
// ----------------------------------------------------------------
`define DMACHR_W8         2'b00
`define DMACHR_W16        2'b01
`define DMACHR_W32        2'b10
`define DMACHR_RST32      32'h0000_0000

`endif

// File: dmachr_checker.sv
// Port checker for the DMA register block.
// Assumes binding onto dmachr_top, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dmachr_checker #(
  parameter NCH = 7
) (
  // Clock, reset and bus
  input wire           SYS_CLK,
  input wire           RST_N,
  input wire [7:0]     AV_ADDRESS,
  input wire           AV_READ,
  input wire           AV_WRITE,
  input wire [31:0]    AV_READDATA,
  input wire           AV_WAITREQUEST,
  // Engine and irqs
  input wire           XFER_REQ,
  input wire           XFER_ACK,
  input wire [2:0]     XFER_CH,
  input wire [31:0]    XFER_PADDR,
  input wire [1:0]     XFER_PWIDTH,
  input wire [NCH-1:0] CH_IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire rd_ok = AV_READ && !AV_WAITREQUEST;
  wire is_cfg = AV_ADDRESS >= 8'h08 && AV_ADDRESS <= 8'h80 &&
                (AV_ADDRESS - 8'h08) % 8'h14 == 8'h00;
  sequence s_wait; XFER_REQ && !XFER_ACK; endsequence
  sequence s_done; XFER_REQ && XFER_ACK; endsequence
  wait_one_a: assert property ($rose(AV_READ || AV_WRITE) |->
    AV_WAITREQUEST ##1 !AV_WAITREQUEST) else $error("bus wait not one");
  sts_resv_a: assert property (rd_ok && AV_ADDRESS == 8'h00 |->
    AV_READDATA[31:28] == 4'h0) else $error("status top bits set");
  clr_zero_a: assert property (rd_ok && AV_ADDRESS == 8'h04 |->
    AV_READDATA == 32'h0) else $error("clear reg not zero");
  cfg_resv_a: assert property (rd_ok && is_cfg |->
    AV_READDATA[31:15] == 17'h0) else $error("config top bits set");
  irq_reset_a: assert property ($rose(RST_N) |->
    CH_IRQ == {NCH{1'b0}}) else $error("irq after reset");
  req_hold_a: assert property (s_wait |=> XFER_REQ &&
    $stable(XFER_CH) && $stable(XFER_PADDR)) else $error("request moved");
  ack_gap_a: assert property (s_done |=> !XFER_REQ)
    else $error("no idle after ack");
  align32_a: assert property (XFER_REQ && XFER_PWIDTH == 2'b10 |->
    XFER_PADDR[1:0] == 2'b00) else $error("paddr not word aligned");
  align16_a: assert property (XFER_REQ && XFER_PWIDTH == 2'b01 |->
    !XFER_PADDR[0]) else $error("paddr not half aligned");
endmodule // dmachr_checker
bind dmachr_top dmachr_checker #(.NCH(NCH)) u_dmachr_checker (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .AV_ADDRESS(AV_ADDRESS),
  .AV_READ(AV_READ), .AV_WRITE(AV_WRITE), .AV_READDATA(AV_READDATA),
  .AV_WAITREQUEST(AV_WAITREQUEST), .XFER_REQ(XFER_REQ), .XFER_ACK(XFER_ACK),
  .XFER_CH(XFER_CH), .XFER_PADDR(XFER_PADDR), .XFER_PWIDTH(XFER_PWIDTH),
  .CH_IRQ(CH_IRQ));
`default_nettype wire

// File: dmachr_engine_model.sv
// Transfer engine model: acks requests after a set delay.
// Assumes the block's clock; errors only on the named channel.
`timescale 1ns/1ps
`default_nettype none
module dmachr_engine_model (
  // Clock, reset, controls
  input  wire       clk,
  input  wire       rst_n,
  input  wire [1:0] delay,
  input  wire [3:0] bad_ch,
  // Engine handshake
  input  wire       xfer_req,
  input  wire [2:0] xfer_ch,
  output reg        xfer_ack,
  output reg        xfer_err
);
  reg [1:0] wait_cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_ack <= 1'b0;
      xfer_err <= 1'b0;
      wait_cnt <= 2'd0;
    end else if (xfer_req && !xfer_ack && wait_cnt == delay) begin
      xfer_ack <= 1'b1;
      xfer_err <= ({1'b0, xfer_ch} == bad_ch);
      wait_cnt <= 2'd0;
    end else begin
      xfer_ack <= 1'b0;
      xfer_err <= 1'b0;
      wait_cnt <= (xfer_req && !xfer_ack) ? wait_cnt + 2'd1 : 2'd0;
    end
  end
endmodule // dmachr_engine_model
`default_nettype wire

// File: tb_dmachr_top.sv
// Testbench for dmachr_top: bus tasks and transfer checks.
// Assumes the engine model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_dmachr_top;
  reg         SYS_CLK = 1'b0;
  reg         RST_N = 1'b0;
  reg  [7:0]  AV_ADDRESS = 8'h00;
  reg         AV_READ = 1'b0;
  reg         AV_WRITE = 1'b0;
  reg  [31:0] AV_WRITEDATA = 32'h0;
  reg  [6:0]  PERIPH_REQ = 7'h00;
  reg  [1:0]  delay = 2'd0;
  reg  [3:0]  bad_ch = 4'hf;
  wire [31:0] AV_READDATA, XFER_PADDR, XFER_MADDR;
  wire        AV_WAITREQUEST, XFER_REQ, XFER_DIR, XFER_COPY;
  wire        XFER_ACK, XFER_ERR;
  wire [2:0]  XFER_CH;
  wire [1:0]  XFER_PWIDTH, XFER_MWIDTH;
  wire [6:0]  CH_IRQ;
  wire [3:0]  xwid = {XFER_MWIDTH, XFER_PWIDTH};
  reg  [3:0]  xw = 4'h0;
  integer     fails = 0;
  integer     n_checks = 0;
  integer     i;
  reg  [31:0] rd;
  always #10 SYS_CLK = ~SYS_CLK;
  dmachr_top u_dmachr_top (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .AV_ADDRESS(AV_ADDRESS), .AV_READ(AV_READ), .AV_WRITE(AV_WRITE),
    .AV_WRITEDATA(AV_WRITEDATA), .AV_BYTEENABLE(4'hf),
    .AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST),
    .PERIPH_REQ(PERIPH_REQ), .XFER_REQ(XFER_REQ), .XFER_CH(XFER_CH),
    .XFER_DIR(XFER_DIR), .XFER_COPY(XFER_COPY), .XFER_PADDR(XFER_PADDR),
    .XFER_MADDR(XFER_MADDR), .XFER_PWIDTH(XFER_PWIDTH),
    .XFER_MWIDTH(XFER_MWIDTH), .XFER_ACK(XFER_ACK), .XFER_ERR(XFER_ERR),
    .CH_IRQ(CH_IRQ));
  dmachr_engine_model u_dmachr_engine_model (.clk(SYS_CLK), .rst_n(RST_N),
    .delay(delay), .bad_ch(bad_ch), .xfer_req(XFER_REQ),
    .xfer_ch(XFER_CH), .xfer_ack(XFER_ACK), .xfer_err(XFER_ERR));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function [7:0] ca(input integer n);
    ca = 8'h08 + 8'h14 * n[7:0];
  endfunction
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task bus(input is_wr, input [7:0] a, input [31:0] d);
    integer n;
    reg w;
    begin
      n = 0;
      @(posedge SYS_CLK);
      AV_ADDRESS <= a;
      AV_WRITEDATA <= d;
      AV_WRITE <= is_wr;
      AV_READ <= !is_wr;
      @(posedge SYS_CLK);
      w = AV_WAITREQUEST;
      while (w !== 1'b0 && n < 40) begin
        @(posedge SYS_CLK);
        w = AV_WAITREQUEST;
        n = n + 1;
      end
      rd = AV_READDATA;
      chk("waitrequest", 32'h0, {31'h0, w});
      AV_READ <= 1'b0;
      AV_WRITE <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rc(input string what, input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(what, e, rd);
    end
  endtask
  task chan(input integer n, input [31:0] cnt, pa, ma, cfg);
    begin
      wr(ca(n) + 8'h08, pa);
      wr(ca(n) + 8'h0c, ma);
      wr(ca(n) + 8'h04, cnt);
      wr(ca(n), cfg);
    end
  endtask
  task xf(input [2:0] c, input [1:0] m, input [31:0] pa, ma);
    integer n;
    begin
      n = 0;
      @(negedge SYS_CLK);
      while (!(XFER_REQ === 1'b1 && XFER_ACK === 1'b1) && n < 100) begin
        @(negedge SYS_CLK);
        n = n + 1;
      end
      chk("xfer_hs", 32'h3, {30'h0, XFER_REQ, XFER_ACK});
      chk("xfer_ch", {29'h0, c}, {29'h0, XFER_CH});
      chk("xfer_width", {28'h0, xw}, {28'h0, xwid});
      chk("xfer_mode", {30'h0, m}, {30'h0, XFER_COPY, XFER_DIR});
      chk("xfer_paddr", pa, XFER_PADDR);
      chk("xfer_maddr", ma, XFER_MADDR);
      @(posedge SYS_CLK);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    #400000;
    fails = fails + 1;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    rc("status", 8'h00, 32'h0);
    rc("clear", 8'h04, 32'h0);
    for (i = 0; i < 7; i = i + 1) rc("config", ca(i), 32'h0);
    rc("unmapped", 8'hfc, 32'h0);
    wr(ca(3), 32'hffff_fffe);
    rc("config", ca(3), 32'h0000_7ffe);
    wr(ca(3), 32'h0);
    $display("test reset and fields done");
    delay <= 2'd2;
    xw = 4'h2;
    PERIPH_REQ <= 7'h01;
    chan(0, 4, 32'h100, 32'h2003, 32'h2c7);
    for (i = 0; i < 4; i = i + 1) xf(0, 0, 32'h100 + 4 * i, 32'h2003 + i);
    PERIPH_REQ <= 7'h00;
    rc("status", 8'h00, 32'h7);
    chk("irq", 32'h1, {25'h0, CH_IRQ});
    wr(8'h04, 32'h4);
    rc("status", 8'h00, 32'h3);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'hf);
    rc("status", 8'h00, 32'h3);
    wr(8'h04, 32'h1);
    rc("status", 8'h00, 32'h0);
    chk("irq", 32'h0, {25'h0, CH_IRQ});
    wr(ca(0), 32'h0);
    $display("test stepping and clears done");
    delay <= 2'd0;
    xw = 4'h0;
    chan(1, 1, 32'h1000, 32'h0, 32'h1);
    chan(2, 1, 32'h2000, 32'h0, 32'h2001);
    chan(3, 1, 32'h3000, 32'h0, 32'h2001);
    PERIPH_REQ <= 7'h0e;
    xf(2, 0, 32'h2000, 32'h0);
    xf(3, 0, 32'h3000, 32'h0);
    xf(1, 0, 32'h1000, 32'h0);
    PERIPH_REQ <= 7'h00;
    rc("status", 8'h00, 32'h7770);
    wr(8'h04, 32'h1110);
    $display("test priority done");
    bad_ch <= 4'h4;
    PERIPH_REQ <= 7'h10;
    chan(4, 2, 32'h40, 32'h80, 32'h9);
    xf(4, 0, 32'h40, 32'h80);
    PERIPH_REQ <= 7'h00;
    rc("status", 8'h00, 32'h0009_0000);
    rc("config", ca(4), 32'h8);
    chk("irq", 32'h10, {25'h0, CH_IRQ});
    wr(8'h04, 32'h1_0000);
    bad_ch <= 4'hf;
    $display("test fault done");
    xw = 4'h5;
    chan(5, 2, 32'h200, 32'h300, 32'h45d1);
    xf(5, 3, 32'h200, 32'h300);
    xf(5, 3, 32'h202, 32'h302);
    $display("test copy done");
    xw = 4'h0;
    PERIPH_REQ <= 7'h40;
    chan(6, 2, 32'h500, 32'h600, 32'h61);
    for (i = 0; i < 4; i = i + 1) xf(6, 0, 32'h500 + i % 2, 32'h600);
    PERIPH_REQ <= 7'h00;
    wr(ca(6), 32'h0);
    $display("test circular done");
    tally_and_finish;
  end
endmodule // tb_dmachr_top
`default_nettype wire
